// ---- shared/rheostat_pkg.sv ----
package rheostat_pkg;

    // frame and word layout
    localparam int          WORD_BITS       = 16;
    localparam int          CMD_MSB         = 13;
    localparam int          CMD_LSB         = 10;
    localparam int          DATA_BITS       = 10;
    localparam int          CTRL_BITS       = 4;
    localparam int          SLOT_BITS       = 6;

    // resolution variant: 10 or 8 wiper bits
    localparam int          RESOLUTION_BITS = 10;
    localparam logic [9:0]  WIPER_LSB_MASK  = (RESOLUTION_BITS == 8) ? 10'h3fc : 10'h3ff;
    localparam logic [9:0]  WIPER_MIDSCALE  = 10'h200;

    // memory slots
    localparam logic [5:0]  SLOT_FIRST      = 6'h01;
    localparam logic [5:0]  SLOT_LAST       = 6'h32;
    localparam int          SLOT_COUNT      = 50;

    // control flag positions
    localparam int          CTRL_PROG_EN    = 0;
    localparam int          CTRL_WIPER_WE   = 1;
    localparam int          CTRL_CAL_DIS    = 2;
    localparam int          CTRL_PROG_OK    = 3;
    localparam logic [3:0]  CTRL_RESET      = 4'h0;
    localparam logic [3:0]  CTRL_WRITABLE   = 4'h7;

    // special words for floating the serial output
    localparam logic [15:0] WORD_FLOAT_ARM  = 16'h8001;
    localparam logic [15:0] WORD_NOP        = 16'h0000;

    // fuse programming time
    localparam int          CLOCK_HZ        = 100_000_000;
    localparam int          PROGRAM_TIME_MS = 350;
    localparam int          PROGRAM_CYCLES  = PROGRAM_TIME_MS * (CLOCK_HZ / 1000);
    localparam int          BUSY_BITS       = 26;

    typedef enum logic [3:0] {
        CMD_NOP         = 4'h0,
        CMD_WIPER_WRITE = 4'h1,
        CMD_WIPER_READ  = 4'h2,
        CMD_STORE       = 4'h3,
        CMD_SOFT_RESET  = 4'h4,
        CMD_MEM_READ    = 4'h5,
        CMD_LAST_ADDR   = 4'h6,
        CMD_CTRL_WRITE  = 4'h7,
        CMD_CTRL_READ   = 4'h8,
        CMD_SHUTDOWN    = 4'h9
    } command_type;

    typedef enum {
        ST_IDLE,
        ST_PROGRAM
    } nvm_state_type;

endpackage : rheostat_pkg

// ---- hw/rheostat_serial_command_control.sv ----
`timescale 1ns/100ps
module rheostat_serial_command_control
    import rheostat_pkg::*;
#(
    parameter int unsigned PROGRAM_CYCLES_P = PROGRAM_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       sclk,
    input  wire logic       frame_select_n,
    input  wire logic       din,
    output logic            sdo_out,
    output logic            sdo_oe,
    output logic [9:0]      wiper_position_register,
    output logic            terminal_a_open,
    output logic            tolerance_cal_disable,
    output logic            nvm_program_busy
);

    // ---------------- link domain (sclk) ----------------
    logic [15:0] link_shift;
    logic [3:0]  link_count;
    logic        link_full;
    logic        frame_open;
    logic        float_link;
    logic [15:0] reply_word;
    logic        sdo_float;

    // frame_select_n high clears the frame-open flag, so the next frame's first edge is known
    always_ff @(posedge sclk or posedge frame_select_n) begin
        if (frame_select_n) begin
            frame_open <= 1'b0;
        end else begin
            frame_open <= 1'b1;
        end
    end

    // input and output share one shift path so chained words pass through delayed by 16
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            link_shift <= 16'h0000;
        end else if (!frame_select_n) begin
            if (!frame_open) begin
                // reply_word is held still while the frame select is low, so it is safe here
                link_shift <= {reply_word[14:0], din};
            end else begin
                link_shift <= {link_shift[14:0], din};
            end
        end
    end

    // bit counter of the open frame; wraps every sixteen bits
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            link_count <= 4'h0;
        end else if (!frame_select_n) begin
            if (!frame_open) begin
                link_count <= 4'h1;
            end else begin
                link_count <= link_count + 4'h1;
            end
        end
    end

    // set once sixteen bits have passed, so a frame of one to fifteen bits is never decoded
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            link_full <= 1'b0;
        end else if (!frame_select_n) begin
            if (!frame_open) begin
                link_full <= 1'b0;
            end else if (link_count == 4'hf) begin
                link_full <= 1'b1;
            end
        end
    end

    // the float decision only moves after a decoded frame, and the next frame opens at least
    // four core cycles later, so it is taken like reply_word; a two-flop stage would need
    // sclk edges that never come between frames and would leak two bits of the next frame
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            float_link <= 1'b0;
        end else if (!frame_select_n && !frame_open) begin
            float_link <= sdo_float;
        end
    end

    // open drain: data is always low, enable pulls the pin low for a zero bit
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            sdo_out <= 1'b0;
            sdo_oe  <= 1'b0;
        end else if (!frame_select_n) begin
            sdo_out <= 1'b0;
            if (!frame_open) begin
                sdo_oe <= sdo_float ? 1'b0 : ~reply_word[15];
            end else if (float_link) begin
                sdo_oe <= 1'b0;
            end else begin
                sdo_oe <= ~link_shift[15];
            end
        end
    end

    // ---------------- core domain (clock) ----------------
    logic          sel_meta;
    logic          sel_sync;
    logic          sel_prev;
    logic          frame_end;
    logic [15:0]   word;
    logic          word_ok;
    command_type   cmd;
    logic [9:0]    data;
    logic [3:0]    ctrl_flags;
    logic [9:0]    otp_wiper_memory [1:SLOT_COUNT];
    logic [5:0]    last_slot;
    logic          float_armed;
    logic          shutdown;
    logic [BUSY_BITS-1:0] busy_count;
    nvm_state_type nvm_state;
    logic          accept;

    function automatic logic [9:0] stored_wiper(input logic [5:0] slot);
        if (slot == 6'h00) begin
            stored_wiper = WIPER_MIDSCALE;
        end else begin
            stored_wiper = otp_wiper_memory[slot];
        end
    endfunction : stored_wiper

    function automatic logic [9:0] slot_value(input logic [5:0] slot);
        if (slot >= SLOT_FIRST && slot <= SLOT_LAST && slot <= last_slot) begin
            slot_value = otp_wiper_memory[slot];
        end else begin
            slot_value = 10'h000;
        end
    endfunction : slot_value

    // a store needs program enable and a free slot; a full memory leaves everything as it is
    function automatic logic store_go(input command_type c, input logic [3:0] flags, input logic [5:0] slot);
        store_go = (c == CMD_STORE) && flags[CTRL_PROG_EN] && (slot < SLOT_LAST);
    endfunction : store_go

    // two flops bring frame select into the core domain; reset at the idle level of the pin
    // so that no false frame end follows reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_meta <= 1'b1;
            sel_sync <= 1'b1;
        end else begin
            sel_meta <= frame_select_n;
            sel_sync <= sel_meta;
        end
    end

    // history of the synchronised select, for the rising edge that ends a frame
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_prev <= 1'b1;
        end else begin
            sel_prev <= sel_sync;
        end
    end

    // link registers are still once frame select has risen, so they are read as settled words
    assign frame_end = sel_sync && !sel_prev;
    assign word      = link_shift;
    assign word_ok   = link_full && (link_count == 4'h0);
    assign cmd       = command_type'(word[CMD_MSB:CMD_LSB]);
    assign data      = word[DATA_BITS-1:0];
    // the input path is locked while a fuse program runs
    assign accept    = frame_end && word_ok && (nvm_state == ST_IDLE);

    // control flags; a write and the end of a store never meet, as no frame is taken
    // while a store runs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_flags <= CTRL_RESET;
        end else if (accept && cmd == CMD_CTRL_WRITE) begin
            // only the three writable flags change; program-ok is hardware owned
            ctrl_flags <= (ctrl_flags & ~CTRL_WRITABLE) | (data[3:0] & CTRL_WRITABLE);
        end else if (nvm_state == ST_PROGRAM && busy_count == '0) begin
            ctrl_flags[CTRL_PROG_OK] <= 1'b1;
        end else if (accept && store_go(cmd, ctrl_flags, last_slot)) begin
            ctrl_flags[CTRL_PROG_OK] <= 1'b0;
        end
    end

    // with writes blocked the wiper only moves by a software reset, which loads the
    // stored value or midscale
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wiper_position_register <= WIPER_MIDSCALE;
        end else if (accept) begin
            if (cmd == CMD_WIPER_WRITE && ctrl_flags[CTRL_WIPER_WE]) begin
                wiper_position_register <= data & WIPER_LSB_MASK;
            end else if (cmd == CMD_SOFT_RESET) begin
                wiper_position_register <= stored_wiper(last_slot);
            end
        end
    end

    // shutdown only opens terminal A; every command keeps working
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shutdown <= 1'b0;
        end else if (accept) begin
            if (cmd == CMD_SHUTDOWN) begin
                shutdown <= data[0];
            end else if (cmd == CMD_SOFT_RESET) begin
                shutdown <= 1'b0;
            end
        end
    end

    // memory writes carry no reset; a slot is only readable once last_slot covers it
    always_ff @(posedge clock) begin
        if (accept && store_go(cmd, ctrl_flags, last_slot)) begin
            otp_wiper_memory[last_slot + 6'h01] <= wiper_position_register;
        end
    end

    // address of the newest slot; stops at fifty
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            last_slot <= 6'h00;
        end else if (accept && store_go(cmd, ctrl_flags, last_slot)) begin
            last_slot <= last_slot + 6'h01;
        end
    end

    // lock timer, loaded as a store starts and run down to zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_count <= '0;
        end else if (nvm_state == ST_IDLE) begin
            if (accept && store_go(cmd, ctrl_flags, last_slot)) begin
                busy_count <= BUSY_BITS'(PROGRAM_CYCLES_P - 1);
            end
        end else if (busy_count != '0) begin
            busy_count <= busy_count - 1'b1;
        end
    end

    // idle, or programming until the timer is spent; accept is held off meanwhile
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nvm_state <= ST_IDLE;
        end else begin
            case (nvm_state)
                ST_IDLE: begin
                    if (accept && store_go(cmd, ctrl_flags, last_slot)) begin
                        nvm_state <= ST_PROGRAM;
                    end
                end
                ST_PROGRAM: begin
                    if (busy_count == '0) begin
                        nvm_state <= ST_IDLE;
                    end
                end
                default: begin
                    nvm_state <= ST_IDLE;
                end
            endcase
        end
    end

    // reply for the next frame; with no readback it echoes the word just received
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reply_word <= 16'h0000;
        end else if (accept) begin
            case (cmd)
                CMD_WIPER_READ: reply_word <= {6'h00, wiper_position_register};
                CMD_MEM_READ:   reply_word <= {6'h00, slot_value(data[SLOT_BITS-1:0])};
                CMD_LAST_ADDR:  reply_word <= {10'h000, last_slot};
                CMD_CTRL_READ:  reply_word <= {12'h000, ctrl_flags};
                default:        reply_word <= word;
            endcase
        end
    end

    // remembers that the last decoded word was the float request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            float_armed <= 1'b0;
        end else if (accept) begin
            float_armed <= (word == WORD_FLOAT_ARM);
        end
    end

    // further no-op frames keep the pin floated; any other word brings it back
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sdo_float <= 1'b0;
        end else if (accept) begin
            if (float_armed && word == WORD_NOP) begin
                sdo_float <= 1'b1;
            end else if (word != WORD_NOP) begin
                sdo_float <= 1'b0;
            end
        end
    end

    // outputs follow their sources one cycle later so each leaves the block from a flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            terminal_a_open <= 1'b0;
        end else begin
            terminal_a_open <= shutdown;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tolerance_cal_disable <= 1'b0;
        end else begin
            tolerance_cal_disable <= ctrl_flags[CTRL_CAL_DIS];
        end
    end

    // busy mirrors the lock so a host can see when the input path opens again
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nvm_program_busy <= 1'b0;
        end else begin
            nvm_program_busy <= (nvm_state == ST_PROGRAM);
        end
    end

endmodule : rheostat_serial_command_control

// ---- sim/serial_host_model.sv ----
`timescale 1ns/100ps
module serial_host_model (
    input  wire logic clock,
    input  wire logic sdo_out,
    input  wire logic sdo_oe,
    output logic      sclk,
    output logic      frame_select_n,
    output logic      din
);
    logic sdo_line;
    // pull-up gives the high level whenever the pin is released
    assign sdo_line = sdo_oe ? sdo_out : 1'b1;

    initial begin
        sclk = 1'b0;
        frame_select_n = 1'b1;
        din = 1'b0;
    end

    // msb first, 48 ns link clock, which stands low outside frames
    task automatic xfer(input logic [31:0] word, input int nbits, output logic [31:0] rx);
        rx = '0;
        @(posedge clock) #1;
        frame_select_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            din = word[i];
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
            rx = {rx[30:0], sdo_line};
        end
        #24 frame_select_n = 1'b1;
        din = ~din;
        repeat (8) @(posedge clock);
    endtask : xfer
endmodule : serial_host_model

// ---- sim/rheostat_serial_command_control_properties.sv ----
`timescale 1ns/100ps
module rheostat_serial_command_control_properties
    import rheostat_pkg::*;
#(
    parameter int unsigned PROGRAM_CYCLES_P = 20
) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       sclk,
    input wire logic       frame_select_n,
    input wire logic       din,
    input wire logic       sdo_out,
    input wire logic       sdo_oe,
    input wire logic [9:0] wiper_position_register,
    input wire logic       terminal_a_open,
    input wire logic       tolerance_cal_disable,
    input wire logic       nvm_program_busy
);
    logic [31:0] busy_len;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_len <= '0;
        end else begin
            busy_len <= nvm_program_busy ? busy_len + 32'h1 : '0;
        end
    end

    chk_sdo_low: assert property (@(posedge clock) disable iff (rst) sdo_out == 1'b0)
        else $error("sdo driven high");
    chk_sdo_idle: assert property (@(posedge clock) disable iff (rst)
        frame_select_n && $past(frame_select_n) |-> $stable(sdo_oe)) else $error("sdo moved between frames");
    chk_wiper_at_end: assert property (@(posedge clock) disable iff (rst)
        $changed(wiper_position_register) |-> frame_select_n && $past(frame_select_n, 3))
        else $error("wiper moved inside a frame");
    chk_shutdown_at_end: assert property (@(posedge clock) disable iff (rst)
        $changed(terminal_a_open) |-> $past(frame_select_n, 4)) else $error("shutdown moved inside a frame");
    chk_cal_at_end: assert property (@(posedge clock) disable iff (rst)
        $changed(tolerance_cal_disable) |-> $past(frame_select_n, 4)) else $error("cal flag moved in frame");
    chk_busy_start: assert property (@(posedge clock) disable iff (rst)
        $rose(nvm_program_busy) |-> $past(frame_select_n, 4)) else $error("store began inside a frame");
    chk_busy_length: assert property (@(posedge clock) disable iff (rst)
        $fell(nvm_program_busy) |-> busy_len == PROGRAM_CYCLES_P) else $error("store time wrong");
    chk_busy_lock: assert property (@(posedge clock) disable iff (rst)
        nvm_program_busy && $past(nvm_program_busy) |-> $stable(wiper_position_register) && $stable(terminal_a_open))
        else $error("state changed while storing");
endmodule : rheostat_serial_command_control_properties

bind rheostat_serial_command_control rheostat_serial_command_control_properties #(
    .PROGRAM_CYCLES_P(PROGRAM_CYCLES_P)
) i_props (.clock, .rst, .sclk, .frame_select_n, .din, .sdo_out, .sdo_oe, .wiper_position_register,
    .terminal_a_open, .tolerance_cal_disable, .nvm_program_busy);

// ---- sim/tb_rheostat_serial_command_control.sv ----
`timescale 1ns/100ps
module tb_rheostat_serial_command_control;
    import rheostat_pkg::*;
    localparam int PROG = 20;
    logic        clock, rst, sclk, frame_select_n, din, sdo_out, sdo_oe;
    logic        terminal_a_open, tolerance_cal_disable, nvm_program_busy;
    logic [9:0]  wiper_position_register;
    logic [31:0] rx;
    int          err_total, n_tests, cycles;

    initial clock = 1'b0;
    always #5 clock = ~clock;

    rheostat_serial_command_control #(.PROGRAM_CYCLES_P(PROG)) i_dut (.clock, .rst, .sclk, .frame_select_n,
        .din, .sdo_out, .sdo_oe, .wiper_position_register, .terminal_a_open, .tolerance_cal_disable,
        .nvm_program_busy);
    serial_host_model i_host (.clock, .sdo_out, .sdo_oe, .sclk, .frame_select_n, .din);

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic word(input logic [15:0] w);
        i_host.xfer({16'h0, w}, 16, rx);
    endtask : word

    // well above the roughly 9000 cycles the sequence needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        rst = 1'b1;
        err_total = 0;
        n_tests = 0;
        cycles = 0;
        repeat (16) @(posedge clock);
        #1 rst = 1'b0;
        repeat (4) @(posedge clock);
        word(16'h2000);
        word(16'h0800);
        chk("ctrl", 16'h0000, rx[15:0]);
        word(16'h0000);
        chk("wiper read", 16'h0200, rx[15:0]);
        $display("test reset state done");
        word(16'h0500);
        chk("wiper", 16'h0200, {6'h0, wiper_position_register});
        word(16'h1c02);
        word(16'h0500);
        chk("wiper", 16'h0100, {6'h0, wiper_position_register});
        word(16'h0c00);
        word(16'h1800);
        word(16'h0000);
        chk("last slot", 16'h0000, rx[15:0]);
        word(16'h1000);
        chk("wiper", 16'h0200, {6'h0, wiper_position_register});
        $display("test protection done");
        word(16'h1c03);
        word(16'h0500);
        chk("echo", 16'h1c03, rx[15:0]);
        word(16'h0c00);
        chk("busy", 16'h0001, {15'h0, nvm_program_busy});
        repeat (PROG + 8) @(posedge clock);
        chk("busy", 16'h0000, {15'h0, nvm_program_busy});
        word(16'h1800);
        word(16'h2000);
        chk("last slot", 16'h0001, rx[15:0]);
        word(16'h1fff);
        chk("ctrl", 16'h000b, rx[15:0]);
        word(16'h2000);
        word(16'h0000);
        chk("ctrl", 16'h000f, rx[15:0]);
        chk("cal off", 16'h0001, {15'h0, tolerance_cal_disable});
        word(16'h1401);
        word(16'h1400);
        chk("slot 1", 16'h0100, rx[15:0]);
        word(16'h0000);
        chk("slot 0", 16'h0000, rx[15:0]);
        $display("test store done");
        word(16'h2401);
        chk("shutdown", 16'h0001, {15'h0, terminal_a_open});
        word(16'h0555);
        chk("wiper", 16'h0155, {6'h0, wiper_position_register});
        word(16'h1000);
        chk("shutdown", 16'h0000, {15'h0, terminal_a_open});
        chk("wiper", 16'h0100, {6'h0, wiper_position_register});
        word(16'h2401);
        word(16'h2400);
        chk("shutdown", 16'h0000, {15'h0, terminal_a_open});
        $display("test shutdown done");
        i_host.xfer(32'h0000_0577, 15, rx);
        chk("short frame", 16'h0100, {6'h0, wiper_position_register});
        i_host.xfer(32'h0123_0566, 32, rx);
        chk("chain out", 16'h0123, rx[15:0]);
        chk("wiper", 16'h0166, {6'h0, wiper_position_register});
        for (int k = 0; k < 50; k++) begin
            word(16'h0c00);
            repeat (PROG + 8) @(posedge clock);
        end
        word(16'h1800);
        word(16'h0c00);
        chk("last slot", 16'h0032, rx[15:0]);
        chk("busy", 16'h0000, {15'h0, nvm_program_busy});
        $display("test full memory done");
        word(16'h8001);
        word(16'h0000);
        word(16'h0000);
        chk("floated", 16'hffff, rx[15:0]);
        $display("test framing done");
        conclude();
    end
endmodule : tb_rheostat_serial_command_control
